// *** msi_cap_defs.vh ***
`ifndef MSI_CAP_DEFS_VH
`define MSI_CAP_DEFS_VH

// configuration dword addresses (byte offsets, dword aligned)
`define CTRL_DWORD_ADDR 8'h48
`define ADDR_LOW_ADDR 8'h4c
`define ADDR_HIGH_ADDR 8'h50
`define DATA_DWORD_ADDR 8'h54
// printed byte offset of the control word inside the 48h dword
`define CTRL_BYTE_OFFSET 8'h4a
`define CTRL_LANE_LSB 16

// control word fields
`define CTRL_RESET 16'h0086
`define CTRL_VEC_MASK_BIT 8
`define CTRL_WIDE_BIT 7
`define CTRL_COUNT_EN_MSB 6
`define CTRL_COUNT_EN_LSB 4
`define CTRL_COUNT_CAP_MSB 3
`define CTRL_COUNT_CAP_LSB 1
`define CTRL_ENABLE_BIT 0
`define COUNT_CAP_VALUE 3'h3
`define VEC_MASK_VALUE 1'h0
`define WIDE_CAP_VALUE 1'h1

// multiple-message enable codes
`define COUNT_ONE 3'h0
`define COUNT_TWO 3'h1
`define COUNT_FOUR 3'h2
`define COUNT_EIGHT 3'h3
`define COUNT_SIXTEEN 3'h4
`define COUNT_THIRTYTWO 3'h5

// address and data registers
`define ADDR_LOW_RESET 32'h00000000
`define ADDR_HIGH_RESET 32'h00000000
`define DATA_RESET 16'h0000
`define ADDR_LOW_RO_MASK 32'h00000003
`define NUM_INTERRUPTERS 8

`endif

// *** message_number_map.v ***
`timescale 1ns/10ps
`include "msi_cap_defs.vh"

module message_number_map (
    input wire [2:0] count_enable,
    input wire [2:0] interrupter,
    input wire [15:0] data_programmed,
    output reg [2:0] message_number,
    output reg [15:0] data_out
);

    reg [15:0] lane_mask;

    always @* begin
        lane_mask = 16'h0000;
        message_number = 3'h0;
        case (count_enable)
            // [R05] single message
            `COUNT_ONE: begin
                message_number = 3'h0;
                lane_mask = 16'h0000;
            end
            // [R06] even and odd split
            `COUNT_TWO: begin
                message_number = {2'h0, interrupter[0]};
                lane_mask = 16'h0001;
            end
            // [R07] index modulo four
            `COUNT_FOUR: begin
                message_number = {1'h0, interrupter[1:0]};
                lane_mask = 16'h0003;
            end
            // [R08] index is message
            `COUNT_EIGHT: begin
                message_number = interrupter;
                lane_mask = 16'h0007;
            end
            // [R19] capped at seven
            `COUNT_SIXTEEN: begin
                message_number = interrupter;
                lane_mask = 16'h000f;
            end
            `COUNT_THIRTYTWO: begin
                message_number = interrupter;
                lane_mask = 16'h001f;
            end
            default: begin
                message_number = interrupter;
                lane_mask = 16'h0007;
            end
        endcase
        // [R17] keep unmodifiable bits
        data_out = (data_programmed & ~lane_mask) |
            ({13'h0000, message_number} & lane_mask);
    end

endmodule // message_number_map

// *** message_write_port.v ***
`timescale 1ns/10ps
`include "msi_cap_defs.vh"

module message_write_port (
    input wire clk_sys,
    input wire rst,
    input wire load,
    input wire [31:0] load_addr_low,
    input wire [31:0] load_addr_high,
    input wire [15:0] load_data,
    input wire msg_ready,
    output wire busy,
    output reg msg_valid,
    output reg [63:0] msg_addr,
    output reg msg_wide,
    output reg [15:0] msg_data
);

    assign busy = msg_valid;

    always @(posedge clk_sys) begin
        if (rst) begin
            msg_valid <= 1'b0;
            msg_addr <= 64'h0000000000000000;
            msg_wide <= 1'b0;
            msg_data <= 16'h0000;
        end else if (load && !msg_valid) begin
            msg_valid <= 1'b1;
            // [R11] low target address
            msg_addr <= {load_addr_high, load_addr_low};
            // [R15] wide when upper nonzero
            msg_wide <= (load_addr_high != 32'h00000000);
            msg_data <= load_data;
        end else if (msg_valid && msg_ready) begin
            msg_valid <= 1'b0;
        end
    end

endmodule // message_write_port

// *** msi_message_capability.v ***
`timescale 1ns/10ps
`include "msi_cap_defs.vh"

// Overview of operation
// [R01] control bits 15:9 read zero, writes ignored
// [R02] vector mask capability bit 8 reads zero, read-only
// [R03] wide address capability bit 7 reads one, read-only
// [R04] message count enable is writable; software avoids codes 110, 111
// [R05] count code 000: every interrupter uses message 0
// [R06] code 001: even interrupters message 0, odd message 1
// [R07] code 010: interrupter index modulo four gives message
// [R08] codes 011, 100, 101: message equals interrupter index
// [R09] message count capability reads 011, eight messages, read-only
// [R10] no message sent while enable bit 0 is clear; a message already loaded in the write port is still sent
// [R11] low address register at 4Ch gives low target address
// [R12] low address bits 31:2 are read-write
// [R13] low address bits 1:0 read zero
// [R14] upper address register at 50h read-write, high address
// [R15] upper zero means 32-bit write, otherwise 64-bit
// [R16] both address registers reset to zero
// [R17] only message number bits of data replaced, rest kept
// [R18] control word resets to 0086h
// [R19] sixteen or thirty-two messages still use only messages 0-7
module msi_message_capability (
    input wire clk_sys,
    input wire rst,
    input wire cfg_wr,
    input wire cfg_rd,
    input wire [7:0] cfg_addr,
    input wire [3:0] cfg_byte_en,
    input wire [31:0] cfg_wdata,
    output reg [31:0] cfg_rdata,
    output reg cfg_rd_valid,
    input wire [7:0] irq_event,
    output reg [7:0] irq_pending,
    output wire message_interrupt_enable,
    output wire [2:0] message_count_enable,
    input wire msg_ready,
    output wire msg_valid,
    output wire [63:0] msg_addr,
    output wire msg_wide,
    output wire [15:0] msg_data
);

    reg enable_reg;
    reg enable_next;
    reg [2:0] count_reg;
    reg [2:0] count_next;
    reg [31:0] addr_low_reg;
    reg [31:0] addr_low_next;
    reg [31:0] addr_high_reg;
    reg [31:0] addr_high_next;
    reg [15:0] data_reg;
    reg [15:0] data_next;
    wire [7:0] pending_next;
    reg [7:0] grant_onehot;
    reg [2:0] grant_index;
    reg grant_any;
    reg [15:0] control_word;
    reg [31:0] read_word;
    wire [15:0] mapped_data;
    wire sender_busy;
    wire sel_ctrl;
    wire sel_low;
    wire sel_high;
    wire sel_data;
    wire wr_ctrl;
    wire wr_low;
    wire wr_high;
    wire wr_data;
    wire launch;
    wire [7:0] lane_bits;
    integer i;

    localparam [15:0] ctrl_reset_word = `CTRL_RESET;

    // one bit per byte lane
    function [31:0] lane_merge;
        input [31:0] old_value;
        input [31:0] new_value;
        input [3:0] lanes;
        integer k;
        begin
            lane_merge = old_value;
            for (k = 0; k < 4; k = k + 1) begin
                if (lanes[k]) begin
                    lane_merge[k*8 +: 8] = new_value[k*8 +: 8];
                end
            end
        end
    endfunction

    function hit;
        input [7:0] addr;
        input [7:0] target;
        begin
            hit = (addr[7:2] == target[7:2]);
        end
    endfunction

    assign message_interrupt_enable = enable_reg;
    assign message_count_enable = count_reg;

    // shared dword decode for reads and writes
    assign sel_ctrl = hit(cfg_addr, `CTRL_DWORD_ADDR);
    assign sel_low = hit(cfg_addr, `ADDR_LOW_ADDR);
    assign sel_high = hit(cfg_addr, `ADDR_HIGH_ADDR);
    assign sel_data = hit(cfg_addr, `DATA_DWORD_ADDR);
    // control sits in the upper half; byte 3 holds only read-only bits
    assign wr_ctrl = cfg_wr && sel_ctrl && cfg_byte_en[2];
    assign wr_low = cfg_wr && sel_low;
    assign wr_high = cfg_wr && sel_high;
    assign wr_data = cfg_wr && sel_data;

    always @* begin
        control_word = 16'h0000;
        // [R01] reserved bits zero
        control_word[15:9] = 7'h00;
        // [R02] no vector masking
        control_word[`CTRL_VEC_MASK_BIT] = `VEC_MASK_VALUE;
        // [R03] wide address capable
        control_word[`CTRL_WIDE_BIT] = `WIDE_CAP_VALUE;
        control_word[`CTRL_COUNT_EN_MSB:`CTRL_COUNT_EN_LSB] = count_reg;
        // [R09] eight messages capable
        control_word[`CTRL_COUNT_CAP_MSB:`CTRL_COUNT_CAP_LSB] =
            `COUNT_CAP_VALUE;
        control_word[`CTRL_ENABLE_BIT] = enable_reg;
    end

    // [R04] writable count field
    always @* begin
        enable_next = enable_reg;
        count_next = count_reg;
        if (wr_ctrl) begin
            count_next = cfg_wdata[`CTRL_LANE_LSB +
                `CTRL_COUNT_EN_LSB +: 3];
            enable_next = cfg_wdata[`CTRL_LANE_LSB +
                `CTRL_ENABLE_BIT];
        end
    end

    // [R12] bits 31:2 writable
    // [R13] bits 1:0 forced zero
    always @* begin
        addr_low_next = addr_low_reg;
        if (wr_low) begin
            addr_low_next = lane_merge(addr_low_reg, cfg_wdata,
                cfg_byte_en) & ~`ADDR_LOW_RO_MASK;
        end
    end

    // [R14] upper address writable
    always @* begin
        addr_high_next = addr_high_reg;
        if (wr_high) begin
            addr_high_next = lane_merge(addr_high_reg, cfg_wdata,
                cfg_byte_en);
        end
    end

    // data register uses lanes 0 and 1 only
    always @* begin
        data_next = data_reg;
        if (wr_data && cfg_byte_en[0]) begin
            data_next[7:0] = cfg_wdata[7:0];
        end
        if (wr_data && cfg_byte_en[1]) begin
            data_next[15:8] = cfg_wdata[15:8];
        end
    end

    // [R18] control reset value
    always @(posedge clk_sys) begin
        if (rst) begin
            enable_reg <= ctrl_reset_word[`CTRL_ENABLE_BIT];
            count_reg <=
                ctrl_reset_word[`CTRL_COUNT_EN_MSB:`CTRL_COUNT_EN_LSB];
        end else begin
            enable_reg <= enable_next;
            count_reg <= count_next;
        end
    end

    // [R16] addresses reset zero
    always @(posedge clk_sys) begin
        if (rst) begin
            addr_low_reg <= `ADDR_LOW_RESET;
            addr_high_reg <= `ADDR_HIGH_RESET;
        end else begin
            addr_low_reg <= addr_low_next;
            addr_high_reg <= addr_high_next;
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            data_reg <= `DATA_RESET;
        end else begin
            data_reg <= data_next;
        end
    end

    // configuration reads
    always @* begin
        read_word = 32'h00000000;
        if (sel_ctrl) begin
            read_word = {control_word, 16'h0000};
        end else if (sel_low) begin
            read_word = addr_low_reg;
        end else if (sel_high) begin
            read_word = addr_high_reg;
        end else if (sel_data) begin
            read_word = {16'h0000, data_reg};
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            cfg_rdata <= 32'h00000000;
            cfg_rd_valid <= 1'b0;
        end else begin
            cfg_rd_valid <= cfg_rd;
            if (cfg_rd) begin
                cfg_rdata <= read_word;
            end
        end
    end

    // lowest pending interrupter wins
    always @* begin
        grant_onehot = 8'h00;
        grant_index = 3'h0;
        grant_any = 1'b0;
        for (i = `NUM_INTERRUPTERS - 1; i >= 0; i = i - 1) begin
            if (irq_pending[i]) begin
                grant_index = i[2:0];
                grant_any = 1'b1;
            end
        end
        if (grant_any) begin
            grant_onehot[grant_index] = 1'b1;
        end
    end

    // [R10] hold new launches while disabled; a message already in the port still goes out
    assign launch = enable_reg && grant_any && !sender_busy;
    assign lane_bits = launch ? grant_onehot : 8'h00;

    genvar g;
    generate
        for (g = 0; g < `NUM_INTERRUPTERS; g = g + 1) begin : pend
            // new event wins over the launch clear
            assign pending_next[g] = irq_event[g] |
                (irq_pending[g] & ~lane_bits[g]);
        end
    endgenerate

    always @(posedge clk_sys) begin
        if (rst) begin
            irq_pending <= 8'h00;
        end else begin
            irq_pending <= pending_next;
        end
    end

    message_number_map u_map (
        .count_enable(count_reg),
        .interrupter(grant_index),
        .data_programmed(data_reg),
        .message_number(),
        .data_out(mapped_data)
    );

    message_write_port u_port (
        .clk_sys(clk_sys),
        .rst(rst),
        .load(launch),
        .load_addr_low(addr_low_reg),
        .load_addr_high(addr_high_reg),
        .load_data(mapped_data),
        .msg_ready(msg_ready),
        .busy(sender_busy),
        .msg_valid(msg_valid),
        .msg_addr(msg_addr),
        .msg_wide(msg_wide),
        .msg_data(msg_data)
    );

endmodule // msi_message_capability

// *** msi_cap_chk.sv ***
`timescale 1ns/10ps
module msi_cap_chk (
    input logic clk_sys,
    input logic rst,
    input logic cfg_rd,
    input logic [7:0] cfg_addr,
    input logic [31:0] cfg_rdata,
    input logic cfg_rd_valid,
    input logic [7:0] irq_pending,
    input logic message_interrupt_enable,
    input logic [2:0] message_count_enable,
    input logic msg_ready,
    input logic msg_valid,
    input logic [63:0] msg_addr,
    input logic msg_wide,
    input logic [15:0] msg_data
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence ctrl_rd;
        cfg_rd_valid && $past(cfg_addr[7:2]) == 6'h12;
    endsequence
    chk_rd_answer:
        assert property (cfg_rd |=> cfg_rd_valid) else $error("read late");
    chk_ctrl_reserved:
        assert property (ctrl_rd |-> cfg_rdata[31:24] == 8'h00)
        else $error("control high bits set");
    chk_ctrl_caps:
        assert property (ctrl_rd |-> cfg_rdata[23] && cfg_rdata[19:17] == 3'h3)
        else $error("capability bits wrong");
    chk_low_align:
        assert property (cfg_rd_valid && $past(cfg_addr[7:2]) == 6'h13
            |-> cfg_rdata[1:0] == 2'h0) else $error("low address unaligned");
    chk_no_send_off:
        assert property (!message_interrupt_enable && !msg_valid |=> !msg_valid)
        else $error("message while disabled");
    chk_msg_holds:
        assert property (msg_valid && !msg_ready |=> msg_valid
            && $stable({msg_addr, msg_data, msg_wide})) else $error("msg moved");
    chk_wide_flag:
        assert property (msg_valid |-> msg_wide == (msg_addr[63:32] != 32'h0))
        else $error("wide flag wrong");
    chk_launch_next:
        assert property (message_interrupt_enable && irq_pending != 8'h0
            && !msg_valid |=> msg_valid) else $error("pending not sent");
    chk_reset_ctrl:
        assert property ($fell(rst) |-> !message_interrupt_enable
            && message_count_enable == 3'h0) else $error("control reset wrong");
    cover property (msg_valid && msg_ready && msg_wide);
    cover property (msg_valid && msg_ready && !msg_wide);
    cover property (msg_valid && !msg_ready);
endmodule // msi_cap_chk

bind msi_message_capability msi_cap_chk chk_i (.clk_sys(clk_sys), .rst(rst),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata),
    .cfg_rd_valid(cfg_rd_valid), .irq_pending(irq_pending),
    .message_interrupt_enable(message_interrupt_enable),
    .message_count_enable(message_count_enable), .msg_ready(msg_ready),
    .msg_valid(msg_valid), .msg_addr(msg_addr), .msg_wide(msg_wide),
    .msg_data(msg_data));

// *** link_sink.sv ***
`timescale 1ns/10ps
module link_sink (
    input logic clk_sys,
    input logic slow,
    input logic msg_valid,
    output logic msg_ready = 1'b0
);
    logic [1:0] cnt_reg = 2'h0;
    // takes one write at a time; slow mode accepts one cycle in four
    always @(posedge clk_sys) begin
        cnt_reg <= cnt_reg + 2'h1;
        msg_ready <= !slow || cnt_reg == 2'h3;
    end
endmodule // link_sink

// *** testbench.sv ***
`timescale 1ns/10ps
module testbench;
    logic clk_sys = 0, rst = 1, cfg_wr = 0, cfg_rd = 0, slow = 0;
    logic [7:0] cfg_addr = 8'h0, irq_event = 8'h0;
    logic [3:0] cfg_byte_en = 4'h0;
    logic [31:0] cfg_wdata = 32'h0, lo, hi;
    logic [15:0] dat;
    logic [2:0] code;
    wire [31:0] cfg_rdata;
    wire cfg_rd_valid, message_interrupt_enable, msg_ready, msg_valid;
    wire msg_wide;
    wire [7:0] irq_pending;
    wire [2:0] message_count_enable;
    wire [63:0] msg_addr;
    wire [15:0] msg_data;
    integer failures = 0, checked = 0, seed = 76;
    logic [80:0] mq[$];
    logic [31:0] rq[$];
    msi_message_capability uut (.clk_sys(clk_sys), .rst(rst),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
        .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_rd_valid(cfg_rd_valid),
        .irq_event(irq_event), .irq_pending(irq_pending),
        .message_interrupt_enable(message_interrupt_enable),
        .message_count_enable(message_count_enable), .msg_ready(msg_ready),
        .msg_valid(msg_valid), .msg_addr(msg_addr), .msg_wide(msg_wide),
        .msg_data(msg_data));
    link_sink partner (.clk_sys(clk_sys), .slow(slow),
        .msg_valid(msg_valid), .msg_ready(msg_ready));
    initial forever #2.5 clk_sys = ~clk_sys;
    task check(input logic [80:0] seen, input logic [80:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge clk_sys);
        cfg_wr <= 1'b1;
        cfg_addr <= a;
        cfg_byte_en <= be;
        cfg_wdata <= d;
        @(posedge clk_sys);
        cfg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        @(posedge clk_sys);
        cfg_rd <= 1'b1;
        cfg_addr <= a;
        @(posedge clk_sys);
        cfg_rd <= 1'b0;
    endtask
    function automatic logic [15:0] data_exp(input logic [2:0] c,
        input logic [2:0] i, input logic [15:0] d);
        logic [15:0] m;
        logic [2:0] n;
        n = c == 3'h0 ? 3'h0 : c == 3'h1 ? i & 3'h1 : c == 3'h2 ? i & 3'h3 : i;
        m = c > 3'h5 ? 16'h7 : (16'h1 << c) - 16'h1;
        return (d & ~m) | ({13'h0, n} & m);
    endfunction
    // second process: compare each result with the oldest note
    always @(posedge clk_sys) begin
        if (cfg_rd_valid)
            check({49'h0, cfg_rdata}, {49'h0, rq.pop_front()});
        if (msg_valid && msg_ready)
            check({msg_wide, msg_addr, msg_data}, mq.pop_front());
    end
    task conclude;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        conclude;
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        rd(8'h48, 32'h00860000);
        rd(8'h4c, 32'h0);
        rd(8'h50, 32'h0);
        wr(8'h48, 4'hf, 32'hffbfffff);
        rd(8'h48, 32'h00b70000);
        wr(8'h4c, 4'hf, 32'hffffffff);
        rd(8'h4c, 32'hfffffffc);
        wr(8'h5c, 4'hf, 32'hffffffff);
        rd(8'h5c, 32'h0);
        for (int c = 0; c < 8; c++) begin
            lo = 32'($random(seed)) & 32'hfffffffc;
            hi = c[0] ? 32'($random(seed)) | 32'h1 : 32'h0;
            dat = 16'($random(seed));
            code = 3'(c % 6);
            slow <= c[1];
            wr(8'h48, 4'h4, 32'h0);
            wr(8'h4c, 4'hf, lo);
            wr(8'h50, 4'hf, hi);
            wr(8'h54, 4'h3, {16'h0, dat});
            rd(8'h50, hi);
            for (int i = 0; i < 8; i++)
                mq.push_back({hi != 0, hi, lo, data_exp(code, i, dat)});
            @(posedge clk_sys);
            irq_event <= 8'hff;
            @(posedge clk_sys);
            irq_event <= 8'h0;
            repeat (6) @(posedge clk_sys);
            check({73'h0, irq_pending}, 81'hff);
            wr(8'h48, 4'h4, {9'h0, code, 3'h0, 1'b1, 16'h0});
            for (int k = 0; k < 200 && mq.size() != 0; k++)
                @(posedge clk_sys);
            check(81'(mq.size()), 81'h0);
            check({77'h0, message_interrupt_enable, message_count_enable},
                {77'h0, 1'b1, code});
        end
        conclude;
    end
endmodule // testbench
